// File: nvbmp_pkg.sv
/*
  Shared constants for the host-side controller of an asynchronous
  byte-wide non-volatile memory: bus widths, array size, cycle timing
  and the power-up wait.
  Assumes a single 25 MHz system clock; all counts derive from it.
*/
package nvbmp_pkg;

  // Memory organisation
  localparam int ADDR_W = 17;                 // Address pins
  localparam int DATA_W = 8;                  // Data pins, one byte
  localparam int WORDS = 131072;              // Addressable bytes

  // System clock period
  localparam int CLK_PERIOD_NS = 40;

  // Least access time for strobe and read data, in ns
  localparam int ACCESS_NS = 35;
  // Least time rounds up to whole cycles, never below one
  localparam int ACCESS_CYC_RAW = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_CYC_RAW < 1) ? 1 : ACCESS_CYC_RAW;

  // Access phase counter
  localparam int ACC_CNT_W = 4;
  localparam logic [ACC_CNT_W-1:0] ACC_CNT_RST = 4'h0;
  localparam logic [ACC_CNT_W-1:0] ACC_CNT_LAST = ACC_CNT_W'(ACCESS_CYC - 1);

  // Startup wait after the supply is good, in ns (2 ms)
  localparam int STARTUP_NS = 2000000;
  // Rounded up, plus one so the hold strictly exceeds the wait
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  // Pin levels after reset: every control inactive high
  localparam logic CTRL_IDLE = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

endpackage

// File: nvbmp_startup_timer.sv
/*
  Power-up wait timer. Counts the startup interval once the supply is
  reported good and restarts from zero whenever it is lost.
  Assumes supply_ok and below_store_block_threshold are synchronous
  level inputs from a supply monitor.
*/
`timescale 1ns/10ps
module nvbmp_startup_timer #(
  parameter int unsigned STARTUP_CYC = nvbmp_pkg::STARTUP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic below_store_block_threshold,
  output logic access_ok
);

  localparam int CNT_W = $clog2(STARTUP_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(STARTUP_CYC);

  logic [CNT_W-1:0] cnt_q; // Cycles of good supply so far
  logic [CNT_W-1:0] cnt_d;
  logic ok_q; // Wait complete
  logic ok_d;
  logic power_good; // Supply above minimum and above inhibit level

  // Next count and done flag
  always_comb begin
    power_good = supply_ok & ~below_store_block_threshold;
    cnt_d = cnt_q;
    ok_d = ok_q;
    if (!power_good) begin
      cnt_d = '0;
      ok_d = 1'b0;
    end else if (cnt_q == CNT_DONE) begin
      ok_d = 1'b1;
    end else begin
      cnt_d = CNT_W'(cnt_q + 1'b1);
      ok_d = 1'b0;
    end
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ok_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      ok_q <= ok_d;
    end
  end

  assign access_ok = ok_q;

endmodule

// File: nvbmp_host.sv
/*
  Host controller for an asynchronous byte-wide non-volatile memory.
  Turns single read and write requests into chip select, write strobe
  and output gate cycles, and keeps the memory idle through power-up.
  Assumes all inputs are synchronous to clk_sys and the outside world
  resolves the data pins from mem_dq_o and mem_dq_oe.
*/
// What this block does
// - Strobe low writes; gate low reads
// - Wait 2 ms after supply good
// - Hold select and strobe high during power-up
// - Brownout restarts the full startup wait
`timescale 1ns/10ps
module nvbmp_host #(
  parameter int ADDR_W = nvbmp_pkg::ADDR_W,
  parameter int DATA_W = nvbmp_pkg::DATA_W,
  parameter int unsigned STARTUP_CYC = nvbmp_pkg::STARTUP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Supply monitor
  input wire logic supply_ok,
  input wire logic below_store_block_threshold,
  // User request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic mem_ready,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_i
);

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_IDLE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RD_WAIT,
    ST_RD_END
  } nvbmp_state_e;

  nvbmp_state_e state_q; // Current phase
  nvbmp_state_e state_d;
  logic [nvbmp_pkg::ACC_CNT_W-1:0] cnt_q; // Cycles spent in the phase
  logic [nvbmp_pkg::ACC_CNT_W-1:0] cnt_d;
  logic access_ok; // Startup wait complete

  // Pin and answer registers, all outputs but mem_ready come from these
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] dq_o_q;
  logic [DATA_W-1:0] dq_o_d;
  logic dq_oe_q;
  logic dq_oe_d;
  logic ce_n_q;
  logic ce_n_d;
  logic we_n_q;
  logic we_n_d;
  logic oe_n_q;
  logic oe_n_d;
  logic ready_q;
  logic ready_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // True when the phase counter has reached the access time
  function automatic logic phase_done(input logic [nvbmp_pkg::ACC_CNT_W-1:0] cnt);
    phase_done = (cnt == nvbmp_pkg::ACC_CNT_LAST);
  endfunction

  // Startup wait, restarted on any supply loss
  nvbmp_startup_timer #(
    .STARTUP_CYC(STARTUP_CYC)
  ) u_startup (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .supply_ok(supply_ok),
    .below_store_block_threshold(below_store_block_threshold),
    .access_ok(access_ok)
  );

  // Sequencer next state and pin values
  always_comb begin
    state_d = state_q;
    cnt_d = nvbmp_pkg::ACC_CNT_RST;
    addr_d = addr_q;
    dq_o_d = dq_o_q;
    dq_oe_d = dq_oe_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    rsp_valid_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      ST_STARTUP: begin
        ce_n_d = nvbmp_pkg::CTRL_IDLE;
        we_n_d = nvbmp_pkg::CTRL_IDLE;
        oe_n_d = nvbmp_pkg::CTRL_IDLE;
        dq_oe_d = 1'b0;
        if (access_ok) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Bus released, memory deselected
        dq_oe_d = 1'b0;
        if (req_valid && ready_q) begin
          addr_d = req_addr;
          ce_n_d = 1'b0;
          if (req_write) begin
            // Data driven before the strobe falls
            dq_o_d = req_wdata;
            dq_oe_d = 1'b1;
            state_d = ST_WR_SETUP;
          end else begin
            oe_n_d = 1'b0;
            state_d = ST_RD_WAIT;
          end
        end
      end
      ST_WR_SETUP: begin
        we_n_d = 1'b0;
        state_d = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (phase_done(cnt_q)) begin
          we_n_d = nvbmp_pkg::CTRL_IDLE;
          ce_n_d = nvbmp_pkg::CTRL_IDLE;
          state_d = ST_WR_END;
        end else begin
          cnt_d = nvbmp_pkg::ACC_CNT_W'(cnt_q + 1'b1);
        end
      end
      ST_WR_END: begin
        dq_oe_d = 1'b0;
        state_d = ST_IDLE;
      end
      ST_RD_WAIT: begin
        // Wait the access time before sampling
        if (phase_done(cnt_q)) begin
          rdata_d = mem_dq_i;
          rsp_valid_d = 1'b1;
          ce_n_d = nvbmp_pkg::CTRL_IDLE;
          oe_n_d = nvbmp_pkg::CTRL_IDLE;
          state_d = ST_RD_END;
        end else begin
          cnt_d = nvbmp_pkg::ACC_CNT_W'(cnt_q + 1'b1);
        end
      end
      ST_RD_END: begin
        // Turnaround cycle so both ends never drive together
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_STARTUP;
      end
    endcase
    if (!access_ok) begin
      state_d = ST_STARTUP;
      ce_n_d = nvbmp_pkg::CTRL_IDLE;
      we_n_d = nvbmp_pkg::CTRL_IDLE;
      oe_n_d = nvbmp_pkg::CTRL_IDLE;
      dq_oe_d = 1'b0;
      rsp_valid_d = 1'b0;
    end
    // Ready only in an idle phase with the wait over
    ready_d = (state_d == ST_IDLE) && access_ok;
  end

  // Sequencer registers, frozen while the enable is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_STARTUP;
      cnt_q <= nvbmp_pkg::ACC_CNT_RST;
      addr_q <= nvbmp_pkg::ADDR_RST;
      dq_o_q <= nvbmp_pkg::DATA_RST;
      dq_oe_q <= 1'b0;
      ce_n_q <= nvbmp_pkg::CTRL_IDLE;
      we_n_q <= nvbmp_pkg::CTRL_IDLE;
      oe_n_q <= nvbmp_pkg::CTRL_IDLE;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rdata_q <= nvbmp_pkg::DATA_RST;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      dq_o_q <= dq_o_d;
      dq_oe_q <= dq_oe_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign mem_ready = access_ok;
  assign mem_addr = addr_q;
  assign mem_ce_n = ce_n_q;
  assign mem_we_n = we_n_q;
  assign mem_oe_n = oe_n_q;
  assign mem_dq_o = dq_o_q;
  assign mem_dq_oe = dq_oe_q;

endmodule

// File: nvbmp_host_assertions.sv
/* Pin and request timing checker for nvbmp_host.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/10ps
module nvbmp_host_assertions #(
  parameter int unsigned STARTUP_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic below_store_block_threshold,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic mem_ready,
  input wire logic [16:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dq_oe,
  input wire logic [7:0] mem_dq_i
);
  logic ok; // Supply usable
  logic take; // Request accepted
  int unsigned good_q, good_d; // Good edges since last loss
  assign ok = supply_ok && !below_store_block_threshold;
  assign take = clk_en && ok && req_valid && req_ready;
  // Good-supply edge count; any loss clears it
  always_comb begin
    good_d = good_q;
    if (clk_en) good_d = ok ? good_q + 1 : 0;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) good_q <= 0;
    else good_q <= good_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_WE_IN_CE: assert property (!mem_we_n |-> !mem_ce_n && mem_oe_n && mem_dq_oe)
    else $error("strobe outside select");
  AST_OE_READ: assert property (!mem_oe_n |-> !mem_ce_n && mem_we_n && !mem_dq_oe)
    else $error("gate clash");
  AST_WR: assert property (take && req_write |=> !mem_ce_n && mem_dq_oe
    && mem_dq_o == $past(req_wdata) && mem_addr == $past(req_addr)
    ##1 (!mem_we_n || !mem_ready)) else $error("write start wrong");
  AST_RD: assert property (take && !req_write |=> !mem_ce_n && !mem_oe_n
    && mem_addr == $past(req_addr) ##1 rsp_valid && rsp_rdata == $past(mem_dq_i))
    else $error("read wrong");
  AST_WE_HOLD: assert property (!mem_we_n |-> $stable(mem_addr) && $stable(mem_dq_o))
    else $error("pins moved in strobe");
  // A write cut by supply loss ends early, so only whole writes are held to this
  AST_WE_END: assert property ($fell(mem_we_n) && mem_ready |=> mem_we_n && mem_ce_n
    && mem_dq_oe && $stable(mem_dq_o) ##1 !mem_dq_oe && (req_ready || !mem_ready))
    else $error("write end wrong");
  // Pins follow the wait flag one edge late, so two idle samples are needed
  AST_IDLE: assert property (!mem_ready && !$past(mem_ready) |-> mem_ce_n && mem_we_n
    && !req_ready) else $error("access before wait");
  // Flag drops first, pins are parked on the following enabled edge
  AST_LOSS: assert property (clk_en && !ok |=> !mem_ready ##1 (!$past(clk_en)
    || mem_ce_n && mem_we_n && !rsp_valid)) else $error("loss not honoured");
  AST_WAIT: assert property ($rose(mem_ready) |-> good_q >= STARTUP_CYC)
    else $error("wait too short");
  // Main scenarios reached
  cover property ($fell(mem_we_n));
  cover property (rsp_valid);
  cover property (!mem_ce_n && !ok);
endmodule

bind nvbmp_host nvbmp_host_assertions #(.STARTUP_CYC(STARTUP_CYC)) i_nvbmp_chk (.*);

// File: nvbmp_mem_model.sv
/* Behavioural byte memory facing nvbmp_host.
   Assumes the bench joins its pins to the host. */
`timescale 1ns/10ps
module nvbmp_mem_model (
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] dq_host,
  input wire logic dq_host_oe,
  input wire logic below_store_block_threshold,
  output logic [7:0] dq
);
  logic [7:0] mem_q [nvbmp_pkg::WORDS];
  logic drive; // Memory drives pins
  // drive on select, gate low, strobe high
  assign drive = !ce_n && !oe_n && we_n;
  // Released pins show the inverse, so stale data never matches
  assign dq = dq_host_oe ? dq_host : drive ? mem_q[addr] : ~mem_q[addr];
  always @* begin
    if (!ce_n && !we_n && !below_store_block_threshold) mem_q[addr] = dq_host;
  end
endmodule

// File: nvbmp_host_test.sv
/* Self-checking bench for nvbmp_host with a memory model.
   Assumes a shortened startup wait. */
`timescale 1ns/10ps
module nvbmp_host_test;
  localparam int SU = 20; // Short startup wait
  typedef struct packed {logic wr; logic [16:0] addr; logic [7:0] data;} nvbmp_row_s;
  logic clk_sys = 1'b0;
  logic rst_n, clk_en, supply_ok, below, req_valid, req_write, req_ready, rsp_valid;
  logic mem_ready, mem_ce_n, mem_we_n, mem_oe_n, mem_dq_oe;
  logic [16:0] req_addr, mem_addr;
  logic [7:0] req_wdata, rsp_rdata, mem_dq_o, mem_dq_i, rd;
  int n_fail = 0;
  int total_checks = 0;
  // Back-to-back accesses, both address ends
  nvbmp_row_s rows [6] = '{'{1'b1, 17'h0_0000, 8'ha5}, '{1'b1, 17'h1_ffff, 8'h3c},
    '{1'b0, 17'h1_ffff, 8'h3c}, '{1'b0, 17'h0_0000, 8'ha5}, '{1'b1, 17'h0_0001, 8'hff},
    '{1'b0, 17'h0_0001, 8'hff}};
  always #20 clk_sys = ~clk_sys;
  nvbmp_host #(.STARTUP_CYC(SU)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .supply_ok(supply_ok), .below_store_block_threshold(below), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));
  nvbmp_mem_model i_mem (.addr(mem_addr), .ce_n(mem_ce_n), .we_n(mem_we_n), .oe_n(mem_oe_n),
    .dq_host(mem_dq_o), .dq_host_oe(mem_dq_oe), .below_store_block_threshold(below),
    .dq(mem_dq_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Edges until ready, counted from the restoring edge
  task automatic wait_up();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (mem_ready !== 1'b1 && n < 200);
    check(n, SU + 2);
  endtask
  // One access; read data lands two edges after the take
  // A set cut drops the supply at the take edge, before the strobe falls
  task automatic op(input nvbmp_row_s r, input logic cut);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    req_valid <= 1'b1;
    req_write <= r.wr;
    req_addr <= r.addr;
    req_wdata <= r.data;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (cut) below <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(32'(rsp_valid), 32'(!r.wr));
    rd = rsp_rdata;
  endtask
  initial begin
    {rst_n, below, req_valid, req_write, req_addr, req_wdata} = '0;
    {clk_en, supply_ok} = 2'b11;
    repeat (6) @(posedge clk_sys);
    check(32'({mem_ce_n, mem_we_n, mem_oe_n, mem_dq_oe, mem_ready}), 32'h0000_001c);
    // Frozen clock enable must not advance the wait
    rst_n <= 1'b1;
    clk_en <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check(32'(mem_ready), 32'h0000_0000);
    clk_en <= 1'b1;
    wait_up();
    $display("test reset and startup done");
    foreach (rows[i]) begin
      op(rows[i], 1'b0);
      if (!rows[i].wr) check(32'(rd), 32'(rows[i].data));
    end
    $display("test row table done");
    // Both kinds of supply loss restart the full wait
    for (int k = 0; k < 2; k++) begin
      if (k == 0) supply_ok <= 1'b0;
      else below <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check(32'(mem_ready), 32'h0000_0000);
      {supply_ok, below} <= 2'b10;
      wait_up();
    end
    $display("test brownout done");
    // Brownout right after a write take leaves the byte untouched
    op('{1'b1, 17'h0_0000, 8'h11}, 1'b1);
    @(posedge clk_sys);
    check(32'(mem_we_n & mem_ce_n), 32'h0000_0001);
    check(32'(mem_ready), 32'h0000_0000);
    below <= 1'b0;
    wait_up();
    op('{1'b0, 17'h0_0000, 8'h00}, 1'b0);
    check(32'(rd), 32'h0000_00a5);
    $display("test aborted write done");
    end_sim();
  end
  // Hang guard, far beyond the planned run
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
endmodule
